// >>> rtl/ckb_defs.svh
// constants for the clock bank disable and invert block
`ifndef CKB_DEFS_SVH
`define CKB_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CKB_CTRL_OFFSET 8'h00
`define CKB_SKEW_OFFSET 8'h04
`define CKB_DIV_OFFSET 8'h08
`define CKB_STAT_OFFSET 8'h0c

// ----------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------
`define CKB_OFF_LSB 0
`define CKB_STYLE_LSB 8
`define CKB_POL_LSB 12
`define CKB_FS_LSB 16
`define CKB_CTRL_MASK 32'h0003331f
`define CKB_SEL_MASK 32'h000fffff
`define CKB_CTRL_RESET 32'h00011000
`define CKB_SKEW_RESET 32'h00044444
`define CKB_DIV_RESET 32'h00011111

// ----------------------------------------------------------------
// skew codes, polarity masks, bus answers
// ----------------------------------------------------------------
`define CKB_SKEW_ZERO 4'h4
`define CKB_SKEW_MAX 4'h8
`define CKB_SKEW_FOLLOW1 4'he
`define CKB_SKEW_FOLLOW2 4'hf
`define CKB_INV_PAIRS 4'hc
`define CKB_INV_ALL 4'hf
`define CKB_RESP_OKAY 2'b00
`define CKB_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// timing: nominal half periods in aclk cycles per range level
// ----------------------------------------------------------------
`define CKB_ACLK_NS 40
`define CKB_HALF_LOW 3'd4
`define CKB_HALF_MID 3'd2
`define CKB_HALF_HIGH 3'd1
`define CKB_PARK_MAX_OUT_CYC 6
`define CKB_SLOW_PERIOD_CYC 96

`endif

// >>> rtl/ckb_pkg.sv
// types for the clock bank disable and invert block
package ckb_pkg;

  typedef enum logic [1:0] {
    CKB_LVL_LOW = 2'b00,
    CKB_LVL_MID = 2'b01,
    CKB_LVL_HIGH = 2'b10
  } ckb_lvl_t;

  typedef enum logic [2:0] {
    CKB_SEL_NONE = 3'b000,
    CKB_SEL_CTRL = 3'b100,
    CKB_SEL_SKEW = 3'b101,
    CKB_SEL_DIV = 3'b110,
    CKB_SEL_STAT = 3'b111
  } ckb_sel_t;

endpackage

// >>> rtl/ckb_bank.sv
// one output bank: divider, skew tap line, parking and polarity
`timescale 1ns/10ps
`include "ckb_defs.svh"
module ckb_bank #(
  parameter int N_OUT = 4
) (
  input logic aclk,
  input logic aresetn,
  input logic nom_edge,
  input logic [3:0] div_ratio,
  input logic [3:0] skew_tap,
  input logic off_request,
  input logic hiz_style,
  input logic test_mode,
  input logic [N_OUT-1:0] invert_mask,
  output logic [N_OUT-1:0] clk_out,
  output logic out_en,
  output logic parked
);
  localparam int PARK_MAX_CYC =
    `CKB_PARK_MAX_OUT_CYC * `CKB_SLOW_PERIOD_CYC;

  logic [3:0] div_cnt, next_div_cnt;
  logic div_clk, next_div_clk;
  logic [15:0] tap_line, next_tap_line;
  logic next_parked;
  logic [N_OUT-1:0] next_clk_out;
  logic [3:0] ratio;
  logic skewed;

  assign ratio = (div_ratio == 4'h0) ? 4'h1 : div_ratio;
  // skew is a tap on the history, independent of polarity
  assign skewed = tap_line[skew_tap];
  // hi-z is combinational: no wait for any edge
  assign out_en = !(off_request && hiz_style && !test_mode);

  always_comb begin
    next_div_cnt = div_cnt;
    next_div_clk = div_clk;
    next_parked = parked;
    if (nom_edge) begin
      if (div_cnt + 4'h1 >= ratio) begin
        next_div_cnt = 4'h0;
        next_div_clk = !div_clk;
      end else begin
        next_div_cnt = div_cnt + 4'h1;
      end
    end
    next_tap_line = {tap_line[14:0], div_clk};
    // park and unpark only while the clock is low: no runt pulses
    if (!skewed) begin
      if (off_request && !hiz_style && !test_mode) begin
        next_parked = 1'b1;
      end else if (!off_request || test_mode) begin
        next_parked = 1'b0;
      end
    end
    // inverting outputs park high, plain ones low
    next_clk_out = {N_OUT{skewed && !(next_parked && !test_mode)}}
      ^ invert_mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 4'h0;
      div_clk <= 1'b0;
      tap_line <= 16'h0000;
      parked <= 1'b0;
      clk_out <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      div_clk <= next_div_clk;
      tap_line <= next_tap_line;
      parked <= next_parked;
      clk_out <= next_clk_out;
    end
  end

  property p_park_bound;
    @(posedge aclk) disable iff (!aresetn)
    $rose(off_request) && !hiz_style && !test_mode |->
      ##[1:PARK_MAX_CYC]
      (parked || !off_request || hiz_style || test_mode);
  endproperty
  a_park_bound: assert property (p_park_bound)
    else $error("bank not parked in time");

  // just out of test the output still follows the clock for a cycle
  property p_park_low;
    @(posedge aclk) disable iff (!aresetn)
    parked && !test_mode && !$past(test_mode) && $stable(invert_mask) |->
      (clk_out & ~invert_mask) == '0;
  endproperty
  a_park_low: assert property (p_park_low)
    else $error("plain output not low while parked");

  property p_park_high;
    @(posedge aclk) disable iff (!aresetn)
    parked && !test_mode && !$past(test_mode) && $stable(invert_mask) |->
      (clk_out & invert_mask) == invert_mask;
  endproperty
  a_park_high: assert property (p_park_high)
    else $error("inverting output not high while parked");

  property p_hiz_now;
    @(posedge aclk) disable iff (!aresetn)
    $rose(off_request) && hiz_style && !test_mode |->
      !out_en && parked == $past(parked);
  endproperty
  a_hiz_now: assert property (p_hiz_now)
    else $error("hi-z not immediate");

  property p_enabled;
    @(posedge aclk) disable iff (!aresetn)
    $fell(off_request) |-> out_en ##[1:PARK_MAX_CYC]
      (!parked || off_request);
  endproperty
  a_enabled: assert property (p_enabled)
    else $error("bank stays off after request dropped");

  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    $fell(parked) && $stable(invert_mask) |->
      !$past(skewed) && (clk_out & ~invert_mask) == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not on a whole period");

  property p_test_on;
    @(posedge aclk) disable iff (!aresetn)
    test_mode && $past(test_mode) && $stable(invert_mask) |-> out_en &&
      (clk_out ^ invert_mask) == {N_OUT{$past(skewed)}};
  endproperty
  a_test_on: assert property (p_test_on)
    else $error("disable acted in factory test");
endmodule

// >>> rtl/ckb_top.sv
// clock bank disable and invert: register slave, loop and banks
`timescale 1ns/10ps
`include "ckb_defs.svh"
// ----------------------------------------------------------------
// How it works
// - every bank, return bank too, is disabled on its own.
// - low off request keeps bank enabled and toggling, in test too.
// - high off request: hi-z if style high, parked if low.
// - parked style stops the bank within six output cycles.
// - parking holds plain outputs low, taken at their falling edge.
// - parking holds inverting outputs high, taken at rising edge.
// - hi-z style releases the whole bank at once, no edge.
// - polarity low: a0, b0 plain; a1, b1 inverted.
// - polarity high: all four third bank outputs inverted.
// - polarity mid: no third bank output inverted.
// - inversion is independent of skew and divide.
// - follow codes give banks 3 and 4 the skew of bank 1 or 2.
// - divide by one runs at the nominal range frequency.
// - two return outputs, four per clock bank, own disables.
// - style mid is factory test: loop bypassed, disables ignored.
// - loop aligns return input rise with primary input rise.
// ----------------------------------------------------------------
module ckb_top #(
  parameter int ADDR_W = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic ref_in,
  input logic loop_return_input,
  output logic [1:0] return_bank_out,
  output logic return_bank_oe,
  output logic [3:0] bank1_out,
  output logic bank1_oe,
  output logic [3:0] bank2_out,
  output logic bank2_oe,
  output logic third_bank_out_a_zero,
  output logic third_bank_out_b_zero,
  output logic third_bank_out_a_one,
  output logic third_bank_out_b_one,
  output logic bank3_oe,
  output logic [3:0] bank4_out,
  output logic bank4_oe
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic ckb_pkg::ckb_sel_t decode(input logic [7:0] a);
    case (a & 8'hfc)
      `CKB_CTRL_OFFSET: decode = ckb_pkg::CKB_SEL_CTRL;
      `CKB_SKEW_OFFSET: decode = ckb_pkg::CKB_SEL_SKEW;
      `CKB_DIV_OFFSET: decode = ckb_pkg::CKB_SEL_DIV;
      `CKB_STAT_OFFSET: decode = ckb_pkg::CKB_SEL_STAT;
      default: decode = ckb_pkg::CKB_SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb,
    input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge = r & mask;
  endfunction

  // follow codes borrow a neighbour's tap; bad codes fall to zero skew
  function automatic logic [3:0] tap_of(input logic [3:0] code,
    input logic [3:0] t1, input logic [3:0] t2);
    if (code == `CKB_SKEW_FOLLOW1) begin
      tap_of = t1;
    end else if (code == `CKB_SKEW_FOLLOW2) begin
      tap_of = t2;
    end else if (code > `CKB_SKEW_MAX) begin
      tap_of = `CKB_SKEW_ZERO;
    end else begin
      tap_of = code;
    end
  endfunction

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl, skew, next_skew, div, next_div;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata, status;
  ckb_pkg::ckb_sel_t wsel, rsel;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wsel = decode(aw_addr);
  assign rsel = decode(s_axi_araddr[7:0]);

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl = ctrl;
    next_skew = skew;
    next_div = div;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wsel == ckb_pkg::CKB_SEL_NONE) ?
        `CKB_RESP_SLVERR : `CKB_RESP_OKAY;
      case (wsel)
        ckb_pkg::CKB_SEL_CTRL:
          next_ctrl = merge(ctrl, w_data, w_strb, `CKB_CTRL_MASK);
        ckb_pkg::CKB_SEL_SKEW:
          next_skew = merge(skew, w_data, w_strb, `CKB_SEL_MASK);
        ckb_pkg::CKB_SEL_DIV:
          next_div = merge(div, w_data, w_strb, `CKB_SEL_MASK);
        default: next_ctrl = ctrl;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `CKB_RESP_OKAY;
      case (rsel)
        ckb_pkg::CKB_SEL_CTRL: next_rdata = ctrl;
        ckb_pkg::CKB_SEL_SKEW: next_rdata = skew;
        ckb_pkg::CKB_SEL_DIV: next_rdata = div;
        ckb_pkg::CKB_SEL_STAT: next_rdata = status;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `CKB_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `CKB_RESP_OKAY;
      ctrl <= `CKB_CTRL_RESET;
      skew <= `CKB_SKEW_RESET;
      div <= `CKB_DIV_RESET;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CKB_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctrl <= next_ctrl;
      skew <= next_skew;
      div <= next_div;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  logic [4:0] off_req, parked, boe;
  ckb_pkg::ckb_lvl_t style, pol3, fs;
  logic test_mode, hiz_style, aligned;
  logic [3:0] pol_mask;
  logic [2:0] half;

  assign off_req = ctrl[`CKB_OFF_LSB +: 5];
  assign style = ckb_pkg::ckb_lvl_t'(ctrl[`CKB_STYLE_LSB +: 2]);
  assign pol3 = ckb_pkg::ckb_lvl_t'(ctrl[`CKB_POL_LSB +: 2]);
  assign fs = ckb_pkg::ckb_lvl_t'(ctrl[`CKB_FS_LSB +: 2]);
  assign test_mode = style == ckb_pkg::CKB_LVL_MID;
  assign hiz_style = style == ckb_pkg::CKB_LVL_HIGH;
  assign status = {25'h0000000, test_mode, aligned, parked};

  always_comb begin
    case (pol3)
      ckb_pkg::CKB_LVL_LOW: pol_mask = `CKB_INV_PAIRS;
      ckb_pkg::CKB_LVL_HIGH: pol_mask = `CKB_INV_ALL;
      default: pol_mask = 4'h0;
    endcase
    case (fs)
      ckb_pkg::CKB_LVL_LOW: half = `CKB_HALF_LOW;
      ckb_pkg::CKB_LVL_HIGH: half = `CKB_HALF_HIGH;
      default: half = `CKB_HALF_MID;
    endcase
  end

  // ----------------------------------------------------------------
  // input synchronisers and phase loop
  // ----------------------------------------------------------------
  logic ref_s1, ref_s2, ref_d, ret_s1, ret_s2, ret_d;
  logic [2:0] nom_cnt, next_nom_cnt;
  logic next_aligned, ref_rise, ret_rise, nom_edge, slip;

  assign ref_rise = ref_s2 && !ref_d;
  assign ret_rise = ret_s2 && !ret_d;
  // crude loop: a primary rise without a return rise restarts phase
  assign slip = !test_mode && ref_rise && !ret_rise;
  // test bypasses the loop and runs banks from the primary input
  assign nom_edge = test_mode ? ref_rise :
    (nom_cnt + 3'd1 >= half);

  always_comb begin
    next_aligned = aligned;
    next_nom_cnt = nom_cnt + 3'd1;
    if (slip || nom_edge) begin
      next_nom_cnt = 3'd0;
    end
    // a slow primary input only works if undivided feedback matches
    if (ref_rise) begin
      next_aligned = ret_rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_d <= 1'b0;
      ret_s1 <= 1'b0;
      ret_s2 <= 1'b0;
      ret_d <= 1'b0;
      nom_cnt <= 3'd0;
      aligned <= 1'b0;
    end else begin
      ref_s1 <= ref_in;
      ref_s2 <= ref_s1;
      ref_d <= ref_s2;
      ret_s1 <= loop_return_input;
      ret_s2 <= ret_s1;
      ret_d <= ret_s2;
      nom_cnt <= next_nom_cnt;
      aligned <= next_aligned;
    end
  end

  // ----------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------
  logic [3:0] tap [0:4];
  logic [3:0] bout [1:4];

  assign tap[0] = tap_of(skew[3:0], `CKB_SKEW_ZERO, `CKB_SKEW_ZERO);
  assign tap[1] = tap_of(skew[7:4], `CKB_SKEW_ZERO, `CKB_SKEW_ZERO);
  assign tap[2] = tap_of(skew[11:8], `CKB_SKEW_ZERO, `CKB_SKEW_ZERO);
  assign tap[3] = tap_of(skew[15:12], tap[1], tap[2]);
  assign tap[4] = tap_of(skew[19:16], tap[1], tap[2]);

  ckb_bank #(.N_OUT(2)) u_return (
    .aclk(aclk),
    .aresetn(aresetn),
    .nom_edge(nom_edge),
    .div_ratio(div[3:0]),
    .skew_tap(tap[0]),
    .off_request(off_req[0]),
    .hiz_style(hiz_style),
    .test_mode(test_mode),
    .invert_mask(2'b00),
    .clk_out(return_bank_out),
    .out_en(boe[0]),
    .parked(parked[0])
  );

  for (genvar g = 1; g < 5; g++) begin : g_bank
    ckb_bank #(.N_OUT(4)) u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .nom_edge(nom_edge),
      .div_ratio(div[4*g +: 4]),
      .skew_tap(tap[g]),
      .off_request(off_req[g]),
      .hiz_style(hiz_style),
      .test_mode(test_mode),
      .invert_mask((g == 3) ? pol_mask : 4'h0),
      .clk_out(bout[g]),
      .out_en(boe[g]),
      .parked(parked[g])
    );
  end

  assign return_bank_oe = boe[0];
  assign bank1_out = bout[1];
  assign bank1_oe = boe[1];
  assign bank2_out = bout[2];
  assign bank2_oe = boe[2];
  assign third_bank_out_a_zero = bout[3][0];
  assign third_bank_out_b_zero = bout[3][1];
  assign third_bank_out_a_one = bout[3][2];
  assign third_bank_out_b_one = bout[3][3];
  assign bank3_oe = boe[3];
  assign bank4_out = bout[4];
  assign bank4_oe = boe[4];

  property p_pol_pairs;
    @(posedge aclk) disable iff (!aresetn)
    pol3 == ckb_pkg::CKB_LVL_LOW && $past(pol3) == pol3 |->
      bout[3][0] != bout[3][2] && bout[3][1] != bout[3][3];
  endproperty
  a_pol_pairs: assert property (p_pol_pairs)
    else $error("third bank pairs not complementary");

  property p_pol_all;
    @(posedge aclk) disable iff (!aresetn)
    pol3 == ckb_pkg::CKB_LVL_HIGH && $past(pol3) == pol3 &&
      parked[3] && !test_mode && !$past(test_mode) |-> bout[3] == 4'hf;
  endproperty
  a_pol_all: assert property (p_pol_all)
    else $error("third bank not all inverted");

  property p_pol_none;
    @(posedge aclk) disable iff (!aresetn)
    pol3 == ckb_pkg::CKB_LVL_MID && $past(pol3) == pol3 |->
      bout[3] == 4'h0 || bout[3] == 4'hf;
  endproperty
  a_pol_none: assert property (p_pol_none)
    else $error("third bank inverted in mid");

  property p_follow;
    @(posedge aclk) disable iff (!aresetn)
    skew[15:12] == `CKB_SKEW_FOLLOW2 && $rose(nom_edge) |->
      tap[3] == tap[2] ##1 $stable(tap[3]) || $changed(skew);
  endproperty
  a_follow: assert property (p_follow)
    else $error("third bank does not follow second skew");
endmodule

// >>> tb/ckb_load_model.sv
// load model: loops the return bank output back to the loop input
`timescale 1ns/10ps
module ckb_load_model (
  input wire logic aclk,
  input wire logic [1:0] return_bank_out,
  input wire logic return_bank_oe,
  output logic loop_return_input
);
  logic last = 1'b0;
  // released pin has no pull: show the inverse of the last level
  always_ff @(posedge aclk) begin
    if (return_bank_oe) begin
      last <= return_bank_out[0];
    end
  end
  assign loop_return_input = return_bank_oe ? return_bank_out[0] :
    !last;
endmodule

// >>> tb/test_clock_bank_disable_invert.sv
// self-checking bench for the clock bank disable and invert block
`timescale 1ns/10ps
`include "ckb_defs.svh"
module test_clock_bank_disable_invert;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ref_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, loop_ret;
  logic [1:0] bresp, rresp, rb_out;
  logic [31:0] rdata;
  logic rb_oe, b1_oe, b2_oe, b3_oe, b4_oe;
  logic [3:0] b1, b2, b4;
  logic t_a0, t_b0, t_a1, t_b1;
  logic [3:0] bout [5];
  logic boe [5];
  logic [31:0] mdl [3];
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] inv;
  int fails = 0, cmp_count = 0, seed = 60, n, pol;

  ckb_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_in(ref_in),
    .loop_return_input(loop_ret), .return_bank_out(rb_out),
    .return_bank_oe(rb_oe), .bank1_out(b1), .bank1_oe(b1_oe),
    .bank2_out(b2), .bank2_oe(b2_oe), .third_bank_out_a_zero(t_a0),
    .third_bank_out_b_zero(t_b0), .third_bank_out_a_one(t_a1),
    .third_bank_out_b_one(t_b1), .bank3_oe(b3_oe), .bank4_out(b4),
    .bank4_oe(b4_oe));

  ckb_load_model load_u (.aclk(aclk), .return_bank_out(rb_out),
    .return_bank_oe(rb_oe), .loop_return_input(loop_ret));

  always_comb begin
    bout[0] = {2'b00, rb_out};
    bout[1] = b1;
    bout[2] = b2;
    bout[3] = {t_b1, t_a1, t_b0, t_a0};
    bout[4] = b4;
    boe[0] = rb_oe;
    boe[1] = b1_oe;
    boe[2] = b2_oe;
    boe[3] = b3_oe;
    boe[4] = b4_oe;
  end

  // ----------------------------------------------------------------
  // clock, reference and watchdog
  // ----------------------------------------------------------------
  initial forever #20 aclk = ~aclk;
  // nominal rate for range mid: half period of two cycles
  initial forever begin
    repeat (2) @(posedge aclk);
    ref_in <= !ref_in;
  end
  initial begin
    #(40 * 20000);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // handshakes judged on values settled before the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic tog(input int k);
    logic [3:0] v;
    logic c;
    v = bout[k];
    c = 1'b0;
    repeat (8) begin
      @(negedge aclk);
      if (bout[k] !== v) c = 1'b1;
    end
    chk(c, 1);
  endtask
  function automatic logic [31:0] ctrl(input int off, sty, p);
    return 32'(off | (sty << 8) | (p << 12) | 32'h00010000);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mdl[0] = `CKB_CTRL_RESET;
    mdl[1] = `CKB_SKEW_RESET;
    mdl[2] = `CKB_DIV_RESET;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4));
      chk(d, mdl[i]);
      d = $random(seed);
      wr(8'(i * 4), d);
      chk(r, `CKB_RESP_OKAY);
      mdl[i] = d & (i == 0 ? `CKB_CTRL_MASK : `CKB_SEL_MASK);
      rd(8'(i * 4));
      chk(d, mdl[i]);
    end
    // second reset: random ratios leave the dividers out of step
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CKB_CTRL_OFFSET);
    chk(d, `CKB_CTRL_RESET);
    // bank 3 borrows the skew of bank 2, bank 4 that of bank 1
    wr(`CKB_SKEW_OFFSET, 32'h000ef324);
    repeat (8) @(negedge aclk);
    for (int k = 0; k < 8; k++) begin
      inv = bout[1];
      @(negedge aclk);
      chk(bout[3], bout[2]);
      chk(bout[4], bout[1]);
      @(negedge aclk);
      chk(bout[1], inv ^ 4'hf);
    end
    // byte strobes: only the low byte may change
    @(posedge aclk);
    wstrb <= 4'h1;
    wr(`CKB_SKEW_OFFSET, 32'hffffff44);
    @(posedge aclk);
    wstrb <= 4'hf;
    rd(`CKB_SKEW_OFFSET);
    chk(d, 32'h000ef344);
    wr(`CKB_SKEW_OFFSET, `CKB_SKEW_RESET);
    wr(`CKB_DIV_OFFSET, `CKB_DIV_RESET);
    wr(8'h10, 32'hffffffff);
    chk(r, `CKB_RESP_SLVERR);
    rd(8'h10);
    chk(d, 32'h0);
    chk(r, `CKB_RESP_SLVERR);
    // park every bank, then bank three under each polarity
    for (int k = 0; k < 7; k++) begin
      n = k < 5 ? k : 3;
      pol = k == 5 ? 0 : (k == 6 ? 2 : 1);
      inv = pol == 0 ? `CKB_INV_PAIRS : (pol == 2 ? `CKB_INV_ALL : 4'h0);
      wr(`CKB_CTRL_OFFSET, ctrl(0, 0, pol));
      tog(n);
      d = (bout[3][0] ^ inv[0]) ? 32'hf : 32'h0;
      chk(bout[3] ^ inv, d);
      wr(`CKB_CTRL_OFFSET, ctrl(1 << n, 0, pol));
      // six output cycles of four clock cycles each at range mid
      repeat (24) @(negedge aclk);
      chk(bout[n], n == 3 ? inv : 4'h0);
      chk(boe[n], 1);
      chk(boe[(n + 1) % 5], 1);
      tog((n + 1) % 5);
      rd(`CKB_STAT_OFFSET);
      chk(d[n], 1);
    end
    wr(`CKB_CTRL_OFFSET, ctrl(4, 2, 1));
    chk(boe[2], 0);
    chk(boe[1], 1);
    wr(`CKB_CTRL_OFFSET, ctrl(5'h1f, 1, 1));
    for (int k = 0; k < 5; k++) chk(boe[k], 1);
    rd(`CKB_STAT_OFFSET);
    chk(d[6], 1);
    tally_and_finish();
  end
endmodule
